// ==== rtl/cod_dictionary.sv ====
// Object dictionary of the communication objects with guarding and history
`timescale 1ns/10ps
module cod_dictionary #(
    parameter int          TICK_CYCLES = cod_pkg::TICK_CYC,
    parameter int          DEPTH       = cod_pkg::HIST_DEPTH,
    parameter logic [31:0] DEV_TYPE    = 32'h0001_0192,
    parameter logic [31:0] NAME_STR    = 32'h4F_50_54_31, // arbitrary
    parameter logic [31:0] HW_STR      = 32'h30_30_31_41, // arbitrary
    parameter logic [31:0] SW_STR      = 32'h30_30_31_42  // arbitrary
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire cod_pkg::cod_req_t req,
    input  wire logic             emcy_valid,
    input  wire logic [31:0]      emcy_code,
    input  wire logic             guard_seen,
    input  wire logic [7:0]       node_addr,
    output      cod_pkg::cod_rsp_t rsp,
    output      logic [1:0]       index_range,
    output      logic             heartbeat_tx,
    output      logic             guard_error,
    output      logic             addr_error,
    output      logic             sync_producer
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        cod_pkg::cod_rsp_t       rsp;
        logic [1:0]              range;
        logic [31:0]             sync_id;
        logic [15:0]             guard_ms;
        logic [7:0]              life;
        logic [31:0]             hb_ms;
        logic [31:0]             hb_cnt;
        logic [31:0]             tick_cnt;
        logic [23:0]             guard_cnt;
        logic                    guard_err;
        logic                    addr_err;
        logic                    hb_pulse;
        logic [CW-1:0]           count;
        logic [DEPTH-1:0][31:0]  hist;
    } cod_state_t;

    cod_state_t st_ff;
    cod_state_t nxt_st;
    logic       tick;
    logic       guard_to;
    logic       log_evt;
    logic [31:0] log_code;

    function automatic logic [1:0] range_of(input logic [15:0] idx);
        if (idx <= cod_pkg::COMM_LAST) begin
            range_of = cod_pkg::RANGE_COMM;
        end else if (idx <= cod_pkg::MFR_LAST) begin
            range_of = cod_pkg::RANGE_MFR;
        end else if (idx <= cod_pkg::PROF_LAST) begin
            range_of = cod_pkg::RANGE_PROF;
        end else begin
            range_of = cod_pkg::RANGE_NONE;
        end
    endfunction

    assign tick     = (st_ff.tick_cnt == 32'(TICK_CYCLES - 1));
    // Product of two settings, both must be nonzero for guarding to run
    assign guard_to = tick && st_ff.guard_ms != 16'h0000
                      && st_ff.life != 8'h00 && !st_ff.guard_err
                      && !guard_seen
                      && (st_ff.guard_cnt + 24'h1 >=
                          st_ff.guard_ms * st_ff.life);
    // Guard timeout wins the log slot over a simultaneous emergency
    assign log_evt  = guard_to || emcy_valid;
    assign log_code = guard_to ? cod_pkg::LIFE_ERR : emcy_code;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rsp = '0;
        nxt_st.hb_pulse = 1'b0;
        nxt_st.addr_err = (node_addr == 8'h00)
                          || (node_addr > cod_pkg::NODE_MAX);
        nxt_st.tick_cnt = tick ? 32'h0 : st_ff.tick_cnt + 32'h1;

        if (st_ff.hb_ms == 32'h0) begin
            nxt_st.hb_cnt = 32'h0;
        end else if (tick) begin
            if (st_ff.hb_cnt + 32'h1 >= st_ff.hb_ms) begin
                nxt_st.hb_cnt   = 32'h0;
                nxt_st.hb_pulse = 1'b1;
            end else begin
                nxt_st.hb_cnt = st_ff.hb_cnt + 32'h1;
            end
        end

        if (guard_seen) begin
            nxt_st.guard_cnt = 24'h0;
            nxt_st.guard_err = 1'b0;
        end else if (st_ff.guard_ms == 16'h0000 || st_ff.life == 8'h00) begin
            // Idle timer held at zero so enabling never times out at once
            nxt_st.guard_cnt = 24'h0;
        end else if (guard_to) begin
            nxt_st.guard_err = 1'b1;
        end else if (tick && !st_ff.guard_err) begin
            nxt_st.guard_cnt = st_ff.guard_cnt + 24'h1;
        end

        if (req.valid) begin
            nxt_st.rsp.valid = 1'b1;
            nxt_st.range     = range_of(req.index);
            if (req.index == cod_pkg::IDX_DEV_TYPE) begin
                nxt_st.rsp.rdata = DEV_TYPE;
                if (req.write) nxt_st.rsp.abort = cod_pkg::AB_RO;
            end else if (req.index == cod_pkg::IDX_FAULT) begin
                nxt_st.rsp.rdata = {31'h0, st_ff.count != '0
                                    || st_ff.guard_err};
                if (req.write) nxt_st.rsp.abort = cod_pkg::AB_RO;
            end else if (req.index == cod_pkg::IDX_HIST) begin
                if (req.sub == 8'h00) begin
                    nxt_st.rsp.rdata = 32'(st_ff.count);
                    if (req.write && req.wdata != 32'h0) begin
                        nxt_st.rsp.abort = cod_pkg::AB_VALUE;
                    end else if (req.write) begin
                        nxt_st.count = '0;
                        nxt_st.hist  = '0;
                    end
                end else if (req.write) begin
                    nxt_st.rsp.abort = cod_pkg::AB_RO;
                end else if (32'(req.sub) <= 32'(st_ff.count)) begin
                    nxt_st.rsp.rdata = st_ff.hist[req.sub - 8'h01];
                end else begin
                    nxt_st.rsp.abort = cod_pkg::AB_SUB;
                end
            end else if (req.index == cod_pkg::IDX_SYNC) begin
                nxt_st.rsp.rdata = st_ff.sync_id;
                if (req.write) nxt_st.sync_id = req.wdata;
            end else if (req.index == cod_pkg::IDX_NAME) begin
                nxt_st.rsp.rdata = NAME_STR;
                if (req.write) nxt_st.rsp.abort = cod_pkg::AB_RO;
            end else if (req.index == cod_pkg::IDX_HW_VER) begin
                nxt_st.rsp.rdata = HW_STR;
                if (req.write) nxt_st.rsp.abort = cod_pkg::AB_RO;
            end else if (req.index == cod_pkg::IDX_SW_VER) begin
                nxt_st.rsp.rdata = SW_STR;
                if (req.write) nxt_st.rsp.abort = cod_pkg::AB_RO;
            end else if (req.index == cod_pkg::IDX_GUARD) begin
                nxt_st.rsp.rdata = {16'h0, st_ff.guard_ms};
                if (req.write) nxt_st.guard_ms = req.wdata[15:0];
            end else if (req.index == cod_pkg::IDX_LIFE) begin
                nxt_st.rsp.rdata = {24'h0, st_ff.life};
                if (req.write) nxt_st.life = req.wdata[7:0];
            end else if (req.index == cod_pkg::IDX_HB_PROD) begin
                nxt_st.rsp.rdata = st_ff.hb_ms;
                if (req.write) nxt_st.hb_ms = req.wdata;
            end else begin
                nxt_st.rsp.abort = cod_pkg::AB_NOOBJ;
            end
        end

        // New error after a clear in the same cycle still lands
        if (log_evt) begin
            nxt_st.hist[0] = log_code;
            for (int i = 1; i < DEPTH; i++) begin
                nxt_st.hist[i] = st_ff.hist[i-1];
            end
            if (nxt_st.count != CW'(DEPTH)) begin
                nxt_st.count = nxt_st.count + CW'(1);
            end
            if (nxt_st.count == CW'(1)) begin
                for (int i = 1; i < DEPTH; i++) nxt_st.hist[i] = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.sync_id <= cod_pkg::SYNC_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rsp           = st_ff.rsp;
    assign index_range   = st_ff.range;
    assign heartbeat_tx  = st_ff.hb_pulse;
    assign guard_error   = st_ff.guard_err;
    assign addr_error    = st_ff.addr_err;
    assign sync_producer = st_ff.sync_id[30];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_hist_clear: assert property (@(posedge clk)
        disable iff (!rst_n)
        req.valid && req.write && req.index == cod_pkg::IDX_HIST
        && req.sub == 8'h00 && req.wdata == 32'h0 && !log_evt
        |=> st_ff.count == '0) else $error("history not cleared");
    a_hist_newest: assert property (@(posedge clk)
        disable iff (!rst_n)
        log_evt |=> st_ff.hist[0] == $past(log_code))
        else $error("newest entry wrong");
    a_hist_bound: assert property (@(posedge clk)
        disable iff (!rst_n)
        st_ff.count <= CW'(DEPTH)) else $error("count overflow");
    a_fault_bit: assert property (@(posedge clk)
        disable iff (!rst_n)
        req.valid && !req.write && req.index == cod_pkg::IDX_FAULT
        && st_ff.guard_err |=> rsp.rdata[cod_pkg::GENERIC_BIT])
        else $error("generic bit clear");
    a_guard_log: assert property (@(posedge clk)
        disable iff (!rst_n)
        guard_to |=> guard_error && st_ff.hist[0] == cod_pkg::LIFE_ERR)
        else $error("guard error not logged");
    a_hb_off: assert property (@(posedge clk)
        disable iff (!rst_n)
        st_ff.hb_ms == 32'h0 |=> !heartbeat_tx)
        else $error("heartbeat while off");
    a_addr_zero: assert property (@(posedge clk)
        disable iff (!rst_n)
        node_addr == 8'h00 |=> addr_error)
        else $error("address zero not flagged");
    a_range_prof: assert property (@(posedge clk)
        disable iff (!rst_n)
        req.valid && req.index >= cod_pkg::PROF_FIRST
        && req.index <= cod_pkg::PROF_LAST
        |=> index_range == cod_pkg::RANGE_PROF)
        else $error("range wrong");
    // Write, one cycle without another guard time write, then read back the guard time
    a_guard_rw: assert property (@(posedge clk)
        disable iff (!rst_n)
        req.valid && req.write && req.index == cod_pkg::IDX_GUARD
        ##1 !(req.valid && req.write && req.index == cod_pkg::IDX_GUARD)
        ##1 req.valid && !req.write && req.index == cod_pkg::IDX_GUARD
        |=> rsp.rdata[15:0] == $past(req.wdata[15:0], 3))
        else $error("guard time lost");
endmodule

// ==== rtl/cod_pkg.sv ====
// Package: object indexes, field layouts, timing constants and carriers
package cod_pkg;
    // ------------------------------------------------------------------
    // Index ranges
    // ------------------------------------------------------------------
    localparam logic [15:0] COMM_LAST    = 16'h1FFF;
    localparam logic [15:0] MFR_FIRST    = 16'h2000;
    localparam logic [15:0] MFR_LAST     = 16'h5FFF;
    localparam logic [15:0] PROF_FIRST   = 16'h6000;
    localparam logic [15:0] PROF_LAST    = 16'h9FFF;
    localparam logic [1:0]  RANGE_COMM   = 2'h0;
    localparam logic [1:0]  RANGE_MFR    = 2'h1;
    localparam logic [1:0]  RANGE_PROF   = 2'h2;
    localparam logic [1:0]  RANGE_NONE   = 2'h3;
    // ------------------------------------------------------------------
    // Object indexes
    // ------------------------------------------------------------------
    localparam logic [15:0] IDX_DEV_TYPE = 16'h1000;
    localparam logic [15:0] IDX_FAULT    = 16'h1001;
    localparam logic [15:0] IDX_HIST     = 16'h1003;
    localparam logic [15:0] IDX_SYNC     = 16'h1005;
    localparam logic [15:0] IDX_NAME     = 16'h1008;
    localparam logic [15:0] IDX_HW_VER   = 16'h1009;
    localparam logic [15:0] IDX_SW_VER   = 16'h100A;
    localparam logic [15:0] IDX_GUARD    = 16'h100C;
    localparam logic [15:0] IDX_LIFE     = 16'h100D;
    localparam logic [15:0] IDX_HB_PROD  = 16'h1017;
    // ------------------------------------------------------------------
    // Fields, reset values, codes
    // ------------------------------------------------------------------
    localparam int          GENERIC_BIT  = 0;
    localparam int          HIST_DEPTH   = 8;
    localparam logic [31:0] SYNC_RST     = 32'h0000_0080;
    localparam logic [31:0] LIFE_ERR     = 32'h0000_8130;
    localparam logic [7:0]  NODE_MAX     = 8'h7E;
    localparam logic [2:0]  AB_NONE      = 3'h0;
    localparam logic [2:0]  AB_RO        = 3'h1;
    localparam logic [2:0]  AB_NOOBJ     = 3'h2;
    localparam logic [2:0]  AB_SUB       = 3'h3;
    localparam logic [2:0]  AB_VALUE     = 3'h4;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_MHZ      = 100;
    localparam int          TICK_US      = 1000;
    localparam int          TICK_CYC     = TICK_US * CLK_MHZ;
    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [31:0] wdata;
    } cod_req_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  abort;
        logic [31:0] rdata;
    } cod_rsp_t;
endpackage

// ==== test/canopen_comm_object_dictionary_test.sv ====
// Self-checking bench for the communication object dictionary
`timescale 1ns/10ps
module canopen_comm_object_dictionary_test;
    typedef struct packed {
        logic        w;
        logic [15:0] idx;
        logic [31:0] val;
        logic [2:0]  ab;
        logic [1:0]  rng;
        logic [1:0]  m;
    } cod_row_t;
    localparam int          TICK  = 4;
    localparam int          DEPTH = 4;
    // Arbitrary identification values; SYW sets bit 30 for the sync producer check
    localparam logic [31:0] DEV   = 32'h0002_0193;
    localparam logic [31:0] NM    = 32'h4142_4344;
    localparam logic [31:0] HW    = 32'h3031_3233;
    localparam logic [31:0] SW    = 32'h3435_3637;
    localparam logic [31:0] SYW   = 32'h4000_0081;
    localparam logic [2:0]  AOK   = cod_pkg::AB_NONE;
    localparam logic [2:0]  ARO   = cod_pkg::AB_RO;
    localparam logic [2:0]  ASB   = cod_pkg::AB_SUB;
    logic              clk        = 1'b0;
    logic              rst_n      = 1'b0;
    logic              emcy_valid = 1'b0;
    logic [31:0]       emcy_code  = 32'h0;
    logic              guard_seen = 1'b0;
    logic [7:0]        node_addr  = 8'h05;
    cod_pkg::cod_req_t req;
    cod_pkg::cod_rsp_t rsp;
    logic [1:0]        index_range;
    logic              heartbeat_tx;
    logic              guard_error;
    logic              addr_error;
    logic              sync_producer;
    logic [2:0]        ab;
    logic [31:0]       rd;
    int                n;
    int                error_cnt  = 0;
    int                checked    = 0;
    logic [7:0]        adr [4]    = '{8'h00, 8'h01, 8'h7E, 8'h7F};
    cod_row_t          rows [23]  = '{
        '{1'b0, 16'h1000, DEV, AOK, 2'h0, 2'h3},
        '{1'b1, 16'h1000, 32'h1, ARO, 2'h0, 2'h2},
        '{1'b0, 16'h1001, 32'h0, AOK, 2'h0, 2'h3},
        '{1'b1, 16'h1001, 32'h1, ARO, 2'h0, 2'h2},
        '{1'b0, 16'h1003, 32'h0, AOK, 2'h0, 2'h3},
        '{1'b0, 16'h1005, 32'h80, AOK, 2'h0, 2'h3},
        '{1'b1, 16'h1005, SYW, AOK, 2'h0, 2'h2},
        '{1'b0, 16'h1005, SYW, AOK, 2'h0, 2'h3},
        '{1'b0, 16'h1008, NM, AOK, 2'h0, 2'h3},
        '{1'b0, 16'h1009, HW, AOK, 2'h0, 2'h3},
        '{1'b0, 16'h100A, SW, AOK, 2'h0, 2'h3},
        '{1'b1, 16'h100A, 32'h0, ARO, 2'h0, 2'h2},
        '{1'b1, 16'h100C, 32'hBEEF, AOK, 2'h0, 2'h2},
        '{1'b0, 16'h100C, 32'hBEEF, AOK, 2'h0, 2'h3},
        '{1'b1, 16'h100C, 32'h0, AOK, 2'h0, 2'h2},
        '{1'b1, 16'h100D, 32'hFF, AOK, 2'h0, 2'h2},
        '{1'b0, 16'h100D, 32'hFF, AOK, 2'h0, 2'h3},
        '{1'b0, 16'h1234, 32'h0, cod_pkg::AB_NOOBJ, 2'h0, 2'h2},
        '{1'b0, 16'h2000, 32'h0, AOK, 2'h1, 2'h0},
        '{1'b0, 16'h5FFF, 32'h0, AOK, 2'h1, 2'h0},
        '{1'b0, 16'h6000, 32'h0, AOK, 2'h2, 2'h0},
        '{1'b0, 16'h9FFF, 32'h0, AOK, 2'h2, 2'h0},
        '{1'b0, 16'hA000, 32'h0, AOK, 2'h3, 2'h0}};
    always #5 clk = ~clk;
    cod_dictionary #(.TICK_CYCLES(TICK), .DEPTH(DEPTH), .DEV_TYPE(DEV),
        .NAME_STR(NM), .HW_STR(HW), .SW_STR(SW)) cod_dictionary_i (
        .clk(clk), .rst_n(rst_n), .req(req), .emcy_valid(emcy_valid),
        .emcy_code(emcy_code), .guard_seen(guard_seen),
        .node_addr(node_addr), .rsp(rsp), .index_range(index_range),
        .heartbeat_tx(heartbeat_tx), .guard_error(guard_error),
        .addr_error(addr_error), .sync_producer(sync_producer));
    cod_master cod_master_i (.clk(clk), .rsp(rsp), .req(req));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic xf(input logic w, input logic [15:0] i,
                      input logic [7:0] s, input logic [31:0] v);
        logic ok;
        cod_master_i.xfer(w, i, s, v, ab, rd, ok);
        chk("rsp_valid", ok, 32'h1);
    endtask
    task automatic rdx(input logic [15:0] i, input logic [7:0] s,
                       input logic [31:0] e);
        xf(1'b0, i, s, 32'h0);
        chk("abort", ab, AOK);
        chk("rdata", rd, e);
    endtask
    task automatic abx(input logic w, input logic [15:0] i,
                       input logic [7:0] s, input logic [31:0] v,
                       input logic [2:0] e);
        xf(w, i, s, v);
        chk("abort", ab, e);
    endtask
    task automatic rst_chk;
        chk("sync_producer", sync_producer, 32'h0);
        chk("guard_error", guard_error, 32'h0);
        chk("rsp_valid_rst", rsp.valid, 32'h0);
    endtask
    task automatic pulse_guard;
        guard_seen = 1'b1;
        @(posedge clk);
        #1;
        guard_seen = 1'b0;
    endtask
    task automatic wait_hb(input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (heartbeat_tx !== 1'b1 && n < lim);
    endtask
    initial begin
        #20000;
        error_cnt++;
        conclude();
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst_chk();
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        foreach (rows[i]) begin
            xf(rows[i].w, rows[i].idx, 8'h00, rows[i].val);
            if (rows[i].m[1]) chk("abort", ab, rows[i].ab);
            if (rows[i].m[0]) chk("rdata", rd, rows[i].val);
            chk("index_range", index_range, rows[i].rng);
        end
        chk("sync_producer", sync_producer, 32'h1);
        for (int i = 0; i <= DEPTH; i++) begin
            emcy_valid = 1'b1;
            emcy_code  = 32'h0000_A000 + 32'(i);
            @(posedge clk);
            #1;
        end
        emcy_valid = 1'b0;
        rdx(16'h1003, 8'h00, 32'(DEPTH));
        rdx(16'h1003, 8'h01, 32'h0000_A000 + 32'(DEPTH));
        rdx(16'h1003, 8'(DEPTH), 32'h0000_A001);
        abx(1'b0, 16'h1003, 8'(DEPTH + 1), 32'h0, ASB);
        rdx(16'h1001, 8'h00, 32'h1);
        abx(1'b1, 16'h1003, 8'h01, 32'h5, ARO);
        abx(1'b1, 16'h1003, 8'h00, 32'h1, cod_pkg::AB_VALUE);
        rdx(16'h1003, 8'h00, 32'(DEPTH));
        abx(1'b1, 16'h1003, 8'h00, 32'h0, AOK);
        rdx(16'h1003, 8'h00, 32'h0);
        rdx(16'h1001, 8'h00, 32'h0);
        abx(1'b0, 16'h1003, 8'h01, 32'h0, ASB);
        abx(1'b1, 16'h100C, 8'h00, 32'h2, AOK);
        abx(1'b1, 16'h100D, 8'h00, 32'h3, AOK);
        pulse_guard();
        repeat (16) @(posedge clk);
        #1;
        chk("guard_early", guard_error, 32'h0);
        repeat (20) @(posedge clk);
        #1;
        chk("guard_late", guard_error, 32'h1);
        rdx(16'h1001, 8'h00, 32'h1);
        rdx(16'h1003, 8'h01, cod_pkg::LIFE_ERR);
        pulse_guard();
        @(posedge clk);
        #1;
        chk("guard_clear", guard_error, 32'h0);
        abx(1'b1, 16'h100D, 8'h00, 32'h0, AOK);
        abx(1'b1, 16'h1017, 8'h00, 32'h2, AOK);
        wait_hb(100);
        wait_hb(100);
        chk("hb_period", n, 32'(2 * TICK));
        abx(1'b1, 16'h1017, 8'h00, 32'h0, AOK);
        wait_hb(40);
        chk("hb_off", n, 32'd40);
        foreach (adr[i]) begin
            node_addr = adr[i];
            repeat (2) @(posedge clk);
            #1;
            chk("addr_error", addr_error,
                32'(adr[i] == 8'h00 || adr[i] > 8'h7E));
        end
        node_addr = 8'h05;
        rst_n = 1'b0;
        #1;
        rst_chk();
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        rdx(16'h1005, 8'h00, 32'h80);
        rdx(16'h1003, 8'h00, 32'h0);
        conclude();
    end
endmodule

// ==== test/cod_master.sv ====
// Network master model issuing dictionary requests one at a time
`timescale 1ns/10ps
module cod_master (
    input  wire logic              clk,
    input  wire cod_pkg::cod_rsp_t rsp,
    output      cod_pkg::cod_req_t req
);
    initial req = '0;
    // ------------------------------------------------------------------
    // One transfer: held to the taking edge, answer read the cycle after
    // ------------------------------------------------------------------
    task automatic xfer(input  logic        w,
                        input  logic [15:0] idx,
                        input  logic [7:0]  sub,
                        input  logic [31:0] wd,
                        output logic [2:0]  ab,
                        output logic [31:0] rd,
                        output logic        ok);
        req <= '{1'b1, w, idx, sub, wd};
        @(posedge clk);
        #1;
        ok = rsp.valid;
        ab = rsp.abort;
        rd = rsp.rdata;
        // Released fields inverted so stale values cannot pass
        req <= '{1'b0, ~w, ~idx, ~sub, ~wd};
        @(posedge clk);
        #1;
    endtask
endmodule
